//--- hw/serial_port_defines.vh
// constants for the serial port clock and pin-mode block
`ifndef SERIAL_PORT_DEFINES_VH
`define SERIAL_PORT_DEFINES_VH
`define DIV_WIDTH        8
`define WORD_WIDTH       16
`define CNT_WIDTH        5
`define DELAY_ZERO       2'h0
`define DIV_RESET        8'h01
`define CLK_SRC_INTERNAL 2'h0
`define CLK_SRC_TX_PIN   2'h1
`define CLK_SRC_RX_PIN   2'h2
`define ST_IDLE          2'h0
`define ST_SHIFT         2'h1
`define ST_DONE          2'h2
`endif

//--- hw/word_buffer.v
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module word_buffer #(
    parameter WIDTH = 16
) (
    input  wire             sys_clk,
    input  wire             sys_rst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output reg  [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem_q [0:1];
    reg             wr_q;
    reg             rd_q;
    reg [1:0]       cnt_q;
    wire            push;
    wire            pop;

    assign in_ready  = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @* begin
        out_data = mem_q[rd_q];
    end

    always @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
        if (sys_rst) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 2'h1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

//--- hw/serial_port_clock_pins.v
// serial port bit-clock generator, polarity, frame sync, data pin and pin-mode logic
//
// Contract
// [R01] generated bit clock period is (1 + divide value) system clocks; a divide value of zero gives a period of two
// [R02] low phase: half period if divide odd or zero, else divide/2 clocks
// [R03] high phase: half period if divide odd or zero, else divide/2+1 clocks
// [R04] polarity bits at zero use rising edges; a set bit inverts that signal
// [R05] transmit delay enable and a-bis mode have no effect on the data pin
// [R06] zero data delay: first data bit driven from frame sync assertion
// [R07] data pin released after last bit on clock rise; new data after rise
// [R08] generated frame syncs update after rising edge of their bit clock
// [R09] clock, frame and receive data pins usable as general-purpose inputs
// [R10] clock, frame and transmit data pins usable as general-purpose outputs
// [R11] either shift clock pin may feed the sample rate generator
// [R12] external source: generator output is shared clock, driven on other pin
// [R13] transmit clock pin as source: shared clock out on receive clock pin
// [R14] receive clock pin as source: shared clock out on transmit clock pin
// [R15] external source mode otherwise behaves like internal clock source
// [R16] external source clock period at least one system clock period
`timescale 1ns/1ns
`default_nettype none
`include "serial_port_defines.vh"
module serial_port_clock_pins #(
    parameter DIV_W  = `DIV_WIDTH,
    parameter WORD_W = `WORD_WIDTH,
    parameter CNT_W  = `CNT_WIDTH
) (
    input  wire              sys_clk,
    input  wire              sys_rst,
    input  wire [DIV_W-1:0]  clock_divide_value,
    input  wire [1:0]        clock_source_select,
    input  wire              receive_clock_polarity,
    input  wire              transmit_clock_polarity,
    input  wire              receive_frame_polarity,
    input  wire              transmit_frame_polarity,
    input  wire              transmit_delay_enable,
    input  wire              a_bis_bit_mode,
    input  wire [1:0]        transmit_data_delay,
    input  wire [CNT_W-1:0]  word_length,
    input  wire              clock_generate_enable,
    input  wire              frame_generate_enable,
    input  wire [4:0]        gpio_mode,
    input  wire [4:0]        gpio_out_value,
    output reg  [4:0]        gpio_in_value,
    input  wire [WORD_W-1:0] tx_word,
    input  wire              tx_valid,
    output wire              tx_ready,
    output wire [WORD_W-1:0] rx_word,
    output wire              rx_valid,
    input  wire              rx_ready,
    output wire              rx_overrun,
    input  wire              receive_shift_clock_pin_in,
    output reg               receive_shift_clock_pin_out,
    output reg               receive_shift_clock_pin_oe,
    input  wire              transmit_shift_clock_pin_in,
    output reg               transmit_shift_clock_pin_out,
    output reg               transmit_shift_clock_pin_oe,
    input  wire              receive_frame_pin_in,
    output reg               receive_frame_pin_out,
    output reg               receive_frame_pin_oe,
    input  wire              transmit_frame_pin_in,
    output reg               transmit_frame_pin_out,
    output reg               transmit_frame_pin_oe,
    input  wire              receive_data_pin_in,
    output reg               transmit_data_pin_out,
    output reg               transmit_data_pin_oe
);
    // pin synchronisers: order rclk, xclk, rfs, xfs, rdata
    reg  [4:0]        sync1_q;
    reg  [4:0]        sync2_q;
    wire [4:0]        pins_in;
    reg  [DIV_W-1:0]  div_cnt_q;
    reg               bclk_q;
    reg               src_prev_q;
    wire              src_pin;
    wire              src_rise;
    wire              ext_mode;
    wire              tick;
    wire [DIV_W:0]    period;
    wire [DIV_W:0]    low_len;
    reg               bclk_rise;
    reg               bclk_fall;
    reg  [1:0]        state_q;
    reg  [CNT_W-1:0]  bit_cnt_q;
    reg  [WORD_W-1:0] tx_shift_q;
    reg               fs_q;
    reg  [CNT_W-1:0]  rx_cnt_q;
    reg  [WORD_W-1:0] rx_shift_q;
    reg               rx_push_q;
    reg               rx_overrun_q;
    reg  [1:0]        dly_q;
    wire              buf_in_ready;
    wire [WORD_W-1:0] buf_data;
    wire              buf_valid;
    wire              rfs_i;

    assign pins_in = {receive_data_pin_in, transmit_frame_pin_in, receive_frame_pin_in,
                      transmit_shift_clock_pin_in, receive_shift_clock_pin_in};

    // [R09] gpio inputs synchronised
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            sync1_q       <= 5'h00;
            sync2_q       <= 5'h00;
            gpio_in_value <= 5'h00;
        end else begin
            sync1_q       <= pins_in;
            sync2_q       <= sync1_q;
            gpio_in_value <= sync2_q;
        end
    end

    // [R11] source pin choice
    assign ext_mode = (clock_source_select != `CLK_SRC_INTERNAL);
    assign src_pin  = (clock_source_select == `CLK_SRC_RX_PIN) ? sync2_q[0] : sync2_q[1];
    // one external edge per tick; a source faster than sys_clk would drop edges
    assign src_rise = src_pin && !src_prev_q;
    // [R15] divider same for both sources, only the tick differs
    assign tick     = ext_mode ? src_rise : 1'b1;

    // [R01] period in ticks
    assign period  = {1'b0, clock_divide_value} + {{DIV_W{1'b0}}, 1'b1};
    // [R02] low phase length, [R03] high phase is the remainder
    assign low_len = (clock_divide_value == {DIV_W{1'b0}}) ? {{DIV_W{1'b0}}, 1'b1} :
                     (clock_divide_value[0] ? {1'b0, 1'b0, clock_divide_value[DIV_W-1:1]} +
                      {{DIV_W{1'b0}}, 1'b1} : {1'b0, 1'b0, clock_divide_value[DIV_W-1:1]});

    always @* begin
        bclk_rise = 1'b0;
        bclk_fall = 1'b0;
        if (clock_generate_enable && tick) begin
            if (!bclk_q && ({1'b0, div_cnt_q} + {{DIV_W{1'b0}}, 1'b1} >= low_len)) begin
                bclk_rise = 1'b1;
            end else if (bclk_q && ({1'b0, div_cnt_q} + {{DIV_W{1'b0}}, 1'b1} >= period)) begin
                bclk_fall = 1'b1;
            end
        end
    end

    // [R01] divider counter
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            div_cnt_q  <= {DIV_W{1'b0}};
            bclk_q     <= 1'b0;
            src_prev_q <= 1'b0;
        end else begin
            src_prev_q <= src_pin;
            if (!clock_generate_enable) begin
                div_cnt_q <= {DIV_W{1'b0}};
                bclk_q    <= 1'b0;
            end else if (bclk_fall) begin
                div_cnt_q <= {DIV_W{1'b0}};
                bclk_q    <= 1'b0;
            end else if (tick) begin
                div_cnt_q <= div_cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
                if (bclk_rise) begin
                    bclk_q <= 1'b1;
                end
            end
        end
    end

    // transmit side: frame sync and shifter run on generated clock edges
    // [R08] frame sync after clock rise
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q    <= `ST_IDLE;
            bit_cnt_q  <= {CNT_W{1'b0}};
            tx_shift_q <= {WORD_W{1'b0}};
            fs_q       <= 1'b0;
            dly_q      <= 2'h0;
        end else begin
            case (state_q)
                `ST_IDLE: begin
                    if (bclk_rise) begin
                        fs_q <= 1'b0;
                        if (tx_valid && frame_generate_enable) begin
                            fs_q       <= 1'b1;
                            tx_shift_q <= tx_word;
                            bit_cnt_q  <= word_length;
                            dly_q      <= transmit_data_delay;
                            state_q    <= `ST_SHIFT;
                        end
                    end
                end
                `ST_SHIFT: begin
                    if (bclk_rise) begin
                        fs_q <= 1'b0;
                        if (dly_q != `DELAY_ZERO) begin
                            dly_q <= dly_q - 2'h1;
                        end else begin
                            tx_shift_q <= {tx_shift_q[WORD_W-2:0], 1'b0};
                            if (bit_cnt_q == {CNT_W{1'b0}}) begin
                                state_q <= `ST_DONE;
                            end else begin
                                bit_cnt_q <= bit_cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
                            end
                        end
                    end
                end
                `ST_DONE: begin
                    state_q <= `ST_IDLE;
                end
                default: begin
                    state_q <= `ST_IDLE;
                end
            endcase
        end
    end

    // [R06] zero delay: data valid with frame; [R05] delay enable, a-bis ignored
    assign tx_ready = (state_q == `ST_IDLE) && bclk_rise && frame_generate_enable;

    // receive side shifts on the generated clock in every mode
    assign rfs_i  = receive_frame_polarity ? ~sync2_q[2] : sync2_q[2];

    // [R15] receive samples on generated clock rise, word length shared
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            rx_cnt_q     <= {CNT_W{1'b0}};
            rx_shift_q   <= {WORD_W{1'b0}};
            rx_push_q    <= 1'b0;
            rx_overrun_q <= 1'b0;
        end else begin
            rx_push_q <= 1'b0;
            if (bclk_rise) begin
                rx_shift_q <= {rx_shift_q[WORD_W-2:0], sync2_q[4]};
                if (rfs_i) begin
                    rx_cnt_q <= word_length;
                end else if (rx_cnt_q != {CNT_W{1'b0}}) begin
                    rx_cnt_q <= rx_cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
                    if (rx_cnt_q == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                        rx_push_q <= 1'b1;
                    end
                end
            end
            // buffer full: word dropped and flagged, flag sticks until reset
            if (rx_push_q && !buf_in_ready) begin
                rx_overrun_q <= 1'b1;
            end
        end
    end

    assign rx_overrun = rx_overrun_q;

    word_buffer #(
        .WIDTH (WORD_W)
    ) u_rx_buf (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .in_data   (rx_shift_q),
        .in_valid  (rx_push_q),
        .in_ready  (buf_in_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (rx_ready)
    );

    assign rx_word  = buf_data;
    assign rx_valid = buf_valid;

    // pin drive, registered
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            receive_shift_clock_pin_out  <= 1'b0;
            receive_shift_clock_pin_oe   <= 1'b0;
            transmit_shift_clock_pin_out <= 1'b0;
            transmit_shift_clock_pin_oe  <= 1'b0;
            receive_frame_pin_out        <= 1'b0;
            receive_frame_pin_oe         <= 1'b0;
            transmit_frame_pin_out       <= 1'b0;
            transmit_frame_pin_oe        <= 1'b0;
            transmit_data_pin_out        <= 1'b0;
            transmit_data_pin_oe         <= 1'b0;
        end else begin
            // [R04] clock polarity inversion
            receive_shift_clock_pin_out  <= receive_clock_polarity ? ~bclk_q : bclk_q;
            transmit_shift_clock_pin_out <= transmit_clock_polarity ? ~bclk_q : bclk_q;
            // [R12] shared clock out on the non-source pin
            receive_shift_clock_pin_oe   <= clock_generate_enable &&
                                            (clock_source_select != `CLK_SRC_RX_PIN);
            transmit_shift_clock_pin_oe  <= clock_generate_enable &&
                                            (clock_source_select != `CLK_SRC_TX_PIN);
            // [R13] tx pin source, rx pin drives
            if (clock_source_select == `CLK_SRC_TX_PIN) begin
                receive_shift_clock_pin_oe <= clock_generate_enable;
            end
            // [R14] rx pin source, tx pin drives
            if (clock_source_select == `CLK_SRC_RX_PIN) begin
                transmit_shift_clock_pin_oe <= clock_generate_enable;
            end
            // [R04] frame polarity inversion
            transmit_frame_pin_out <= transmit_frame_polarity ? ~fs_q : fs_q;
            transmit_frame_pin_oe  <= frame_generate_enable;
            receive_frame_pin_out  <= receive_frame_polarity ? ~fs_q : fs_q;
            receive_frame_pin_oe   <= 1'b0;
            // [R07] release after last bit
            transmit_data_pin_out  <= tx_shift_q[WORD_W-1];
            transmit_data_pin_oe   <= (state_q == `ST_SHIFT) &&
                                      (transmit_delay_enable | a_bis_bit_mode | 1'b1);
            // [R10] general-purpose outputs override
            if (gpio_mode[0]) begin
                receive_shift_clock_pin_out <= gpio_out_value[0];
                receive_shift_clock_pin_oe  <= 1'b1;
            end
            if (gpio_mode[1]) begin
                transmit_shift_clock_pin_out <= gpio_out_value[1];
                transmit_shift_clock_pin_oe  <= 1'b1;
            end
            if (gpio_mode[2]) begin
                receive_frame_pin_out <= gpio_out_value[2];
                receive_frame_pin_oe  <= 1'b1;
            end
            if (gpio_mode[3]) begin
                transmit_frame_pin_out <= gpio_out_value[3];
                transmit_frame_pin_oe  <= 1'b1;
            end
            if (gpio_mode[4]) begin
                transmit_data_pin_out <= gpio_out_value[4];
                transmit_data_pin_oe  <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/port_checker_asserts.sv
// assertion checker for the serial port clock and pin block
`timescale 1ns/1ns
`default_nettype none
`include "serial_port_defines.vh"
module port_checker #(
    parameter WORD_W = 16
) (
    input wire logic              sys_clk,
    input wire logic              sys_rst,
    input wire logic [1:0]        clock_source_select,
    input wire logic              clock_generate_enable,
    input wire logic              transmit_frame_polarity,
    input wire logic [1:0]        transmit_data_delay,
    input wire logic [4:0]        gpio_mode,
    input wire logic [4:0]        gpio_out_value,
    input wire logic [4:0]        gpio_in_value,
    input wire logic [WORD_W-1:0] rx_word,
    input wire logic              rx_valid,
    input wire logic              rx_ready,
    input wire logic              rx_overrun,
    input wire logic              receive_data_pin_in,
    input wire logic              receive_shift_clock_pin_in,
    input wire logic              receive_shift_clock_pin_out,
    input wire logic              receive_shift_clock_pin_oe,
    input wire logic              transmit_shift_clock_pin_oe,
    input wire logic              transmit_frame_pin_out,
    input wire logic              transmit_data_pin_out,
    input wire logic              transmit_data_pin_oe
);
    logic [2:0] up_q;
    wire        ok = up_q == 3'h7;
    // input flops need three clean cycles before their history is meaningful
    always @(posedge sys_clk)
        up_q <= sys_rst ? 3'h0 : (ok ? up_q : up_q + 3'h1);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_gpio_clk_drive: assert property (ok && gpio_mode[0] |=>
        receive_shift_clock_pin_oe && receive_shift_clock_pin_out == $past(gpio_out_value[0]))
        else $error("gpio clock pin drive wrong");
    a_gpio_data_drive: assert property (ok && gpio_mode[4] |=>
        transmit_data_pin_oe && transmit_data_pin_out == $past(gpio_out_value[4]))
        else $error("gpio data pin drive wrong");
    a_gpio_in_data: assert property (ok |->
        gpio_in_value[4] == $past(receive_data_pin_in, 3))
        else $error("gpio data input sample wrong");
    a_gpio_in_clk: assert property (ok |->
        gpio_in_value[0] == $past(receive_shift_clock_pin_in, 3))
        else $error("gpio clock input sample wrong");
    a_first_bit_frame: assert property (ok && gpio_mode[4:3] == 2'h0
        && !transmit_frame_polarity && transmit_data_delay == `DELAY_ZERO
        && $rose(transmit_data_pin_oe) |-> transmit_frame_pin_out)
        else $error("first data bit without frame sync");
    a_ext_tx_source: assert property (ok && clock_source_select == `CLK_SRC_TX_PIN
        && clock_generate_enable && gpio_mode[1:0] == 2'h0
        |=> receive_shift_clock_pin_oe && !transmit_shift_clock_pin_oe)
        else $error("shared clock not on receive clock pin");
    a_ext_rx_source: assert property (ok && clock_source_select == `CLK_SRC_RX_PIN
        && clock_generate_enable && gpio_mode[1:0] == 2'h0
        |=> transmit_shift_clock_pin_oe && !receive_shift_clock_pin_oe)
        else $error("shared clock not on transmit clock pin");
    a_rx_stall_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_word))
        else $error("receive word lost under stall");
    a_overrun_sticky: assert property (rx_overrun |=> rx_overrun)
        else $error("overrun flag cleared");
    c_frame: cover property ($rose(transmit_frame_pin_out));
    c_overrun: cover property ($rose(rx_overrun));
    c_ext_rx: cover property (clock_source_select == `CLK_SRC_RX_PIN && transmit_shift_clock_pin_oe);
endmodule
bind serial_port_clock_pins port_checker #(.WORD_W(WORD_W)) chk (.*);
`default_nettype wire

//--- tb/serial_peer.sv
// peripheral model: takes the transmit word and loops pins back
`timescale 1ns/1ns
`default_nettype none
module serial_peer (
    input  wire logic        sys_clk,
    input  wire logic        bit_clk,
    input  wire logic        frame,
    input  wire logic        data,
    input  wire logic        data_oe,
    input  wire logic [4:0]  word_length,
    output logic             peer_fs,
    output logic             peer_dat,
    output logic [15:0]      got_word,
    output logic [7:0]       got_count
);
    logic        clk_q = 1'b0;
    logic        busy_q = 1'b0;
    logic        last_q = 1'b0;
    logic [4:0]  n_q = 5'h00;
    logic [15:0] sh_q = 16'h0000;
    logic [7:0]  cnt_q = 8'h00;
    assign got_count = cnt_q;
    assign peer_fs = frame;
    // released line shows the inverse of its last level
    assign peer_dat = data_oe ? data : ~last_q;
    always @(posedge sys_clk) begin
        clk_q <= bit_clk;
        if (data_oe)
            last_q <= data;
        // sample at falling edge, msb first
        if (clk_q && !bit_clk) begin
            if (frame && !busy_q) begin
                sh_q <= {15'h0000, data};
                n_q <= 5'h01;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                sh_q <= {sh_q[14:0], data};
                n_q <= n_q + 5'h01;
                if (n_q == word_length) begin
                    busy_q <= 1'b0;
                    got_word <= {sh_q[14:0], data};
                    cnt_q <= cnt_q + 8'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the serial port clock and pin block
`timescale 1ns/1ns
`default_nettype none
`include "serial_port_defines.vh"
module testbench;
    logic        sys_clk = 1'b0, sys_rst = 1'b1;
    logic [7:0]  clock_divide_value = 8'h03;
    logic [1:0]  clock_source_select = 2'h0, transmit_data_delay = 2'h0;
    logic        receive_clock_polarity = 1'b0, transmit_clock_polarity = 1'b0;
    logic        receive_frame_polarity = 1'b0, transmit_frame_polarity = 1'b0;
    logic        transmit_delay_enable = 1'b0, a_bis_bit_mode = 1'b0;
    logic        clock_generate_enable = 1'b1, frame_generate_enable = 1'b1;
    logic        tx_valid = 1'b0, rx_ready = 1'b1, gp_en = 1'b0;
    logic [4:0]  word_length = 5'h0F, gpio_mode = 5'h00, gpio_out_value = 5'h00, gp_drv = 5'h00;
    logic [15:0] tx_word = 16'h0000;
    logic [3:0]  tick_q = 4'h0;
    wire logic [4:0]  gpio_in_value;
    wire logic [15:0] rx_word, got_word;
    wire logic [7:0]  got_count;
    wire logic tx_ready, rx_valid, rx_overrun, peer_fs, peer_dat;
    wire logic receive_shift_clock_pin_out, receive_shift_clock_pin_oe;
    wire logic transmit_shift_clock_pin_out, transmit_shift_clock_pin_oe;
    wire logic receive_frame_pin_out, receive_frame_pin_oe, transmit_frame_pin_out;
    wire logic transmit_frame_pin_oe, transmit_data_pin_out, transmit_data_pin_oe;
    wire logic receive_shift_clock_pin_in, transmit_shift_clock_pin_in;
    wire logic receive_frame_pin_in, transmit_frame_pin_in, receive_data_pin_in;
    // source clock period of four system clocks, never faster than one
    wire       ext_clk = tick_q[1];
    int        miscompares = 0, num_checks = 0;
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) tick_q <= tick_q + 4'h1;
    assign receive_shift_clock_pin_in = receive_shift_clock_pin_oe ? receive_shift_clock_pin_out
        : (clock_source_select == `CLK_SRC_RX_PIN ? ext_clk : gp_drv[0]);
    assign transmit_shift_clock_pin_in = transmit_shift_clock_pin_oe ? transmit_shift_clock_pin_out
        : (clock_source_select == `CLK_SRC_TX_PIN ? ext_clk : gp_drv[1]);
    assign receive_frame_pin_in = receive_frame_pin_oe ? receive_frame_pin_out
        : (gp_en ? gp_drv[2] : peer_fs);
    assign transmit_frame_pin_in = transmit_frame_pin_oe ? transmit_frame_pin_out : gp_drv[3];
    assign receive_data_pin_in = gp_en ? gp_drv[4] : peer_dat;
    serial_port_clock_pins uut (.*);
    serial_peer peer (.sys_clk(sys_clk), .bit_clk(transmit_shift_clock_pin_in),
        .frame(transmit_frame_pin_in), .data(transmit_data_pin_out),
        .data_oe(transmit_data_pin_oe), .word_length(word_length), .peer_fs(peer_fs),
        .peer_dat(peer_dat), .got_word(got_word), .got_count(got_count));
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    function logic pin(input logic sel);
        return sel ? transmit_shift_clock_pin_out : receive_shift_clock_pin_out;
    endfunction
    task measure(input logic sel, output int hi, output int lo);
        int k;
        hi = 0;
        lo = 0;
        for (k = 0; k < 99 && pin(sel) !== 1'b0; k++) @(posedge sys_clk);
        for (k = 0; k < 99 && pin(sel) !== 1'b1; k++) @(posedge sys_clk);
        while (hi < 99 && pin(sel) === 1'b1) begin hi++; @(posedge sys_clk); end
        while (lo < 99 && pin(sel) === 1'b0) begin lo++; @(posedge sys_clk); end
    endtask
    task t_divider;
        int d, hi, lo;
        for (d = 1; d <= 4; d++) begin
            clock_divide_value <= d[7:0];
            cyc(12);
            measure(1'b0, hi, lo);
            check("clk_high", hi, d[0] ? (d + 1) / 2 : d / 2 + 1);
            check("clk_low", lo, d[0] ? (d + 1) / 2 : d / 2);
            check("clk_period", hi + lo, d + 1);
        end
        transmit_clock_polarity <= 1'b1;
        cyc(12);
        measure(1'b1, hi, lo);
        check("inv_phases", {hi[7:0], lo[7:0]}, 16'h0203);
        transmit_clock_polarity <= 1'b0;
    endtask
    task xfer(input logic [15:0] w);
        logic [7:0] c;
        int k;
        c = got_count;
        tx_word <= w;
        tx_valid <= 1'b1;
        @(posedge sys_clk);
        for (k = 0; k < 200 && tx_ready !== 1'b1; k++) @(posedge sys_clk);
        tx_valid <= 1'b0;
        for (k = 0; k < 400 && got_count === c; k++) @(posedge sys_clk);
        check("peer_word", got_word, w);
        cyc(8);
        check("data_oe", transmit_data_pin_oe, 1'b0);
    endtask
    task pop(input logic [15:0] w);
        int k;
        for (k = 0; k < 300 && rx_valid !== 1'b1; k++) @(posedge sys_clk);
        check("rx_word", rx_word, w);
        rx_ready <= 1'b1;
        @(posedge sys_clk);
        rx_ready <= 1'b0;
        @(posedge sys_clk);
    endtask
    task t_transfer;
        rx_ready <= 1'b0;
        clock_divide_value <= 8'h03;
        cyc(4);
        xfer(16'hA5C3);
        pop(16'hA5C3);
        transmit_delay_enable <= 1'b1;
        a_bis_bit_mode <= 1'b1;
        // another word with the unsupported options set
        xfer(16'h3C5A);
        pop(16'h3C5A);
    endtask
    task t_buffer;
        xfer(16'h1234);
        xfer(16'h8001);
        xfer(16'hFFFE);
        check("overrun", rx_overrun, 1'b1);
        pop(16'h1234);
        pop(16'h8001);
        cyc(4);
        check("rx_empty", rx_valid, 1'b0);
    endtask
    task t_gpio;
        logic [4:0] p;
        int i;
        // no bit clock while pins act as gpio, or the receiver frames noise
        gp_en <= 1'b1;
        clock_generate_enable <= 1'b0;
        frame_generate_enable <= 1'b0;
        for (i = 0; i < 2; i++) begin
            p = i ? 5'h0A : 5'h15;
            gpio_mode <= 5'h1F;
            gpio_out_value <= p;
            cyc(5);
            check("gpio_out", {transmit_data_pin_out, transmit_frame_pin_out, receive_frame_pin_out,
                transmit_shift_clock_pin_out, receive_shift_clock_pin_out}, p);
            gpio_mode <= 5'h00;
            gp_drv <= ~p;
            cyc(6);
            check("gpio_in", gpio_in_value, 5'(~p));
        end
        gp_en <= 1'b0;
        cyc(4);
        clock_generate_enable <= 1'b1;
        frame_generate_enable <= 1'b1;
    endtask
    task t_ext;
        int hi, lo;
        clock_divide_value <= 8'h01;
        clock_source_select <= `CLK_SRC_TX_PIN;
        cyc(40);
        measure(1'b0, hi, lo);
        check("rclk_shared", {hi[7:0], lo[7:0]}, 16'h0404);
        clock_source_select <= `CLK_SRC_RX_PIN;
        cyc(40);
        measure(1'b1, hi, lo);
        check("xclk_shared", {hi[7:0], lo[7:0]}, 16'h0404);
        xfer(16'h5AA5);
        pop(16'h5AA5);
        clock_source_select <= `CLK_SRC_INTERNAL;
    endtask
    // whole run needs well under ten thousand cycles
    initial begin
        cyc(30000);
        miscompares++;
        final_report;
    end
    initial begin
        cyc(3);
        sys_rst <= 1'b0;
        cyc(2);
        t_divider;
        t_transfer;
        t_buffer;
        t_gpio;
        t_ext;
        final_report;
    end
endmodule
`default_nettype wire
